// ===== hw/bsx_core.sv
// datapath for bit ops, shifts, index/stack ops and flags instructions
// assumes the sequencer holds req_i until done_o and returns the read
// byte on mem_rdata_i while the read strobe stands, taken at its end
`timescale 1ns/100ps
`default_nettype none
module bsx_core (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // sequencer request
  input wire logic req_valid_i,
  input var bsx_pkg::bsx_req_t req_i,
  output logic done_o,
  output logic illegal_o,
  output logic branch_taken_o,
  // internal memory bus
  output var bsx_pkg::bsx_mem_t mem_o,
  input wire logic [7:0] mem_rdata_i,
  // architectural state
  output logic [7:0] acc_a_o,
  output logic [7:0] acc_b_o,
  output logic [15:0] index_x_o,
  output logic [15:0] index_y_o,
  output logic [15:0] sp_o,
  output logic [7:0] flags_o
);
  import bsx_pkg::*;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_HIGH = 2'b10,
    ST_DONE = 2'b11
  } bsx_state_t;

  bsx_state_t state;
  logic [7:0] acc_a, acc_b, flags, rbyte;
  logic [15:0] ix, iy, sp, sel_w;
  logic [15:0] next_d, next_x, next_y, next_sp;
  logic [7:0] next_flags;
  logic next_a_en;
  logic [7:0] opnd8, res8, tst8;
  logic c_out;
  logic mem_op, mem_rmw, mode_ok, word_op, shift8;

  // set or clear one flag bit in a byte
  function automatic logic [7:0] put_bit(input logic [7:0] f,
                                         input int pos, input logic v);
    logic [7:0] r;
    r = f;
    r[pos] = v;
    return r;
  endfunction

  // n and z from a result, with v and c
  function automatic logic [7:0] nzvc(input logic [7:0] f,
      input logic n, input logic z, input logic v, input logic c);
    logic [7:0] r;
    r = f;
    r[FLG_N] = n;
    r[FLG_Z] = z;
    r[FLG_V] = v;
    r[FLG_C] = c;
    return r;
  endfunction

  function automatic logic [15:0] pick(input bsx_reg_t s,
      input logic [15:0] x, input logic [15:0] y, input logic [15:0] p);
    logic [15:0] r;
    r = (s == REG_X) ? x : ((s == REG_Y) ? y : p);
    return r;
  endfunction

  assign acc_a_o = acc_a;
  assign acc_b_o = acc_b;
  assign index_x_o = ix;
  assign index_y_o = iy;
  assign sp_o = sp;
  assign flags_o = flags;

  // memory bit ops decode only direct and indexed modes
  assign mode_ok = (req_i.mode == MODE_DIR) || (req_i.mode == MODE_INDX) ||
                   (req_i.mode == MODE_INDY);
  assign mem_rmw = (req_i.op == OP_MEM_BITS_SET) ||
                   (req_i.op == OP_MEM_BITS_CLEAR) ||
                   (req_i.op == OP_BRANCH_IF_SET) ||
                   (req_i.op == OP_BRANCH_IF_CLEAR);
  assign word_op = (req_i.op == OP_COMPARE_X) || (req_i.op == OP_COMPARE_Y) ||
                   ((req_i.op == OP_PULL_REG) && (req_i.sel != REG_SP)) ||
                   (req_i.op == OP_LOAD_REG);
  assign shift8 = (req_i.op >= OP_ARITH_LEFT) &&
                  (req_i.op <= OP_ROTATE_RIGHT);
  assign sel_w = pick(req_i.sel, ix, iy, sp);
  assign tst8 = ((req_i.op == OP_BIT_TEST_A) ? acc_a : acc_b) & rbyte;
  assign mem_op = mem_rmw || (req_i.opnd == OPR_MEM && shift8) ||
      req_i.op == OP_BIT_TEST_A || req_i.op == OP_BIT_TEST_B ||
      (word_op && req_i.op != OP_PULL_REG && req_i.mode != MODE_IMM);

  // shifter on the byte operand
  always_comb begin
    case (req_i.opnd)
      OPR_ACC_A: opnd8 = acc_a;
      OPR_ACC_B: opnd8 = acc_b;
      default: opnd8 = rbyte;
    endcase
    res8 = opnd8;
    c_out = flags[FLG_C];
    case (req_i.op)
      OP_ARITH_LEFT, OP_LOGIC_LEFT: begin // same operation
        res8 = {opnd8[6:0], 1'b0};
        c_out = opnd8[7];
      end
      OP_ARITH_RIGHT: begin
        res8 = {opnd8[7], opnd8[7:1]}; // sign kept
        c_out = opnd8[0];
      end
      OP_LOGIC_RIGHT: begin
        res8 = {1'b0, opnd8[7:1]};
        c_out = opnd8[0];
      end
      OP_ROTATE_LEFT: begin
        res8 = {opnd8[6:0], flags[FLG_C]};
        c_out = opnd8[7];
      end
      OP_ROTATE_RIGHT: begin
        res8 = {flags[FLG_C], opnd8[7:1]};
        c_out = opnd8[0];
      end
      OP_MEM_BITS_SET: res8 = rbyte | req_i.mask;
      OP_MEM_BITS_CLEAR: res8 = rbyte & ~req_i.mask;
      default: res8 = opnd8;
    endcase
  end

  // register-only results
  always_comb begin
    logic [15:0] d, sel_v, w, diff;
    logic [16:0] wide;
    d = {acc_a, acc_b};
    next_d = d;
    next_x = ix;
    next_y = iy;
    next_sp = sp;
    next_flags = flags;
    next_a_en = 1'b0;
    wide = '0;
    sel_v = pick(req_i.sel, ix, iy, sp);
    w = (req_i.mode == MODE_IMM) ? req_i.word : {req_i.word[15:8], rbyte};
    diff = 16'(sel_v - w);
    case (req_i.op)
      OP_DOUBLE_LEFT: begin
        next_d = {d[14:0], 1'b0};
        next_flags = nzvc(flags, d[14], next_d == WORD_ZERO,
                          d[15] ^ d[14], d[15]);
      end
      OP_DOUBLE_LOGIC_RIGHT: begin
        next_d = {1'b0, d[15:1]};
        next_flags = nzvc(flags, 1'b0, next_d == WORD_ZERO, d[0], d[0]);
      end
      OP_SWAP_D_X: begin
        next_d = ix;
        next_x = d;
      end
      OP_SWAP_D_Y: begin
        next_d = iy;
        next_y = d;
      end
      OP_SP_TO_X: next_x = 16'(sp + WORD_ONE);
      OP_SP_TO_Y: next_y = 16'(sp + WORD_ONE);
      OP_X_TO_SP: next_sp = 16'(ix - WORD_ONE);
      OP_Y_TO_SP: next_sp = 16'(iy - WORD_ONE);
      OP_ADD_B_X: next_x = 16'(ix + {8'h00, acc_b});
      OP_ADD_B_Y: next_y = 16'(iy + {8'h00, acc_b});
      OP_COMPARE_X, OP_COMPARE_Y: begin // flags only
        wide = {1'b0, sel_v} - {1'b0, w};
        next_flags = nzvc(flags, diff[15], diff == WORD_ZERO,
            (sel_v[15] ^ w[15]) & (sel_v[15] ^ diff[15]), wide[16]);
      end
      OP_CLEAR_CARRY: next_flags = put_bit(flags, FLG_C, 1'b0);
      OP_SET_CARRY: next_flags = put_bit(flags, FLG_C, 1'b1);
      OP_CLEAR_INT_MASK: next_flags = put_bit(flags, FLG_I, 1'b0);
      OP_SET_INT_MASK: next_flags = put_bit(flags, FLG_I, 1'b1);
      OP_CLEAR_OVERFLOW: next_flags = put_bit(flags, FLG_V, 1'b0);
      OP_SET_OVERFLOW: next_flags = put_bit(flags, FLG_V, 1'b1);
      OP_A_TO_FLAGS: begin // stop bit follows a; nmi mask only clears
        next_flags = acc_a;
        next_flags[FLG_X] = flags[FLG_X] & acc_a[FLG_X];
      end
      OP_FLAGS_TO_ACC_A: next_a_en = 1'b1;
      default: next_d = d;
    endcase
  end

  // sequencing and memory strobes
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= ST_IDLE;
      mem_o <= '0;
      rbyte <= BYTE_ZERO;
      done_o <= 1'b0;
      illegal_o <= 1'b0;
      branch_taken_o <= 1'b0;
    end else begin
      mem_o.rd <= 1'b0;
      mem_o.wr <= 1'b0;
      done_o <= 1'b0;
      illegal_o <= 1'b0;
      branch_taken_o <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (req_valid_i && mem_rmw && !mode_ok) begin
            illegal_o <= 1'b1;
            done_o <= 1'b1;
            state <= ST_DONE;
          end else if (req_valid_i && mem_op) begin
            mem_o.rd <= 1'b1; // full 16-bit address space
            mem_o.addr <= req_i.addr;
            state <= ST_WAIT;
          end else if (req_valid_i && req_i.op == OP_PULL_REG) begin
            mem_o.rd <= 1'b1; // read at sp plus one; pointer bumped after read
            mem_o.addr <= 16'(sp + WORD_ONE);
            state <= ST_WAIT;
          end else if (req_valid_i && req_i.op == OP_PUSH_REG) begin
            mem_o.wr <= 1'b1; // write at next free slot
            mem_o.addr <= sp;
            mem_o.wdata <= (req_i.sel == REG_Y) ? iy[7:0] : ix[7:0];
            done_o <= 1'b1;
            state <= ST_DONE;
          end else if (req_valid_i && req_i.op == OP_STORE_REG) begin
            mem_o.wr <= 1'b1;
            mem_o.addr <= req_i.addr;
            mem_o.wdata <= sel_w[15:8];
            state <= ST_HIGH;
          end else if (req_valid_i) begin
            done_o <= 1'b1;
            state <= ST_DONE;
          end
        end
        ST_WAIT: begin
          rbyte <= mem_rdata_i;
          if ((req_i.op == OP_MEM_BITS_SET) ||
              (req_i.op == OP_MEM_BITS_CLEAR)) begin
            mem_o.wr <= 1'b1; // write back to same address
            mem_o.wdata <= (req_i.op == OP_MEM_BITS_SET) ?
                           (mem_rdata_i | req_i.mask) :
                           (mem_rdata_i & ~req_i.mask);
          end
          state <= ST_HIGH;
        end
        ST_HIGH: begin
          if (req_i.op == OP_STORE_REG) begin
            mem_o.wr <= 1'b1;
            mem_o.addr <= 16'(mem_o.addr + WORD_ONE);
            mem_o.wdata <= sel_w[7:0];
          end else if (req_i.opnd == OPR_MEM && shift8) begin
            mem_o.wr <= 1'b1; // shifted byte back to memory
            mem_o.wdata <= res8;
          end
          branch_taken_o <= (req_i.op == OP_BRANCH_IF_SET) ?
                            ((rbyte & req_i.mask) == req_i.mask) :
                            (req_i.op == OP_BRANCH_IF_CLEAR) &&
                            ((rbyte & req_i.mask) == BYTE_ZERO);
          done_o <= 1'b1;
          state <= ST_DONE;
        end
        default: if (!req_valid_i) state <= ST_IDLE;
      endcase
    end
  end

  // architectural registers, committed at the end of an operation
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_a <= BYTE_ZERO;
      acc_b <= BYTE_ZERO;
      ix <= WORD_ZERO;
      iy <= WORD_ZERO;
      sp <= SP_RST;
      flags <= FLAGS_RST;
    end else if ((state == ST_IDLE && req_valid_i && !mem_op &&
                  req_i.op != OP_PULL_REG && req_i.op != OP_STORE_REG &&
                  !(mem_rmw && !mode_ok))) begin
      acc_a <= next_a_en ? flags : next_d[15:8];
      acc_b <= next_d[7:0];
      ix <= next_x;
      iy <= next_y;
      sp <= next_sp;
      flags <= next_flags;
      if (shift8) begin
        if (req_i.opnd == OPR_ACC_A) acc_a <= res8;
        if (req_i.opnd == OPR_ACC_B) acc_b <= res8;
        flags <= nzvc(flags, res8[7], res8 == BYTE_ZERO,
                      res8[7] ^ c_out, c_out);
      end
      if (req_i.op == OP_PUSH_REG) sp <= 16'(sp - WORD_ONE);
      if (req_i.op == OP_INC_REG || req_i.op == OP_DEC_REG) begin
        case (req_i.sel)
          REG_X: ix <= (req_i.op == OP_INC_REG) ? 16'(ix + WORD_ONE) :
                                                  16'(ix - WORD_ONE);
          REG_Y: iy <= (req_i.op == OP_INC_REG) ? 16'(iy + WORD_ONE) :
                                                  16'(iy - WORD_ONE);
          default: sp <= (req_i.op == OP_INC_REG) ? 16'(sp + WORD_ONE) :
                                                    16'(sp - WORD_ONE);
        endcase
      end
      if (req_i.op == OP_LOAD_REG && req_i.mode == MODE_IMM) begin
        case (req_i.sel)
          REG_X: ix <= req_i.word;
          REG_Y: iy <= req_i.word;
          default: sp <= req_i.word;
        endcase
      end
    end else if (state == ST_HIGH) begin
      if (req_i.op == OP_BIT_TEST_A || req_i.op == OP_BIT_TEST_B) begin
        flags <= nzvc(flags, tst8[7], tst8 == BYTE_ZERO, 1'b0,
                      flags[FLG_C]);
      end
      if (req_i.opnd == OPR_MEM && shift8) begin
        flags <= nzvc(flags, res8[7], res8 == BYTE_ZERO,
                      res8[7] ^ c_out, c_out);
      end
      if (req_i.op == OP_COMPARE_X || req_i.op == OP_COMPARE_Y) begin
        flags <= next_flags;
      end
      if (req_i.op == OP_PULL_REG) begin
        sp <= 16'(sp + WORD_ONE);
        if (req_i.sel == REG_X) ix <= {8'h00, rbyte};
        if (req_i.sel == REG_Y) iy <= {8'h00, rbyte};
      end
      if (req_i.op == OP_LOAD_REG) begin
        case (req_i.sel)
          REG_X: ix <= {req_i.word[15:8], rbyte};
          REG_Y: iy <= {req_i.word[15:8], rbyte};
          default: sp <= {req_i.word[15:8], rbyte};
        endcase
      end
    end
  end

  a_nmi_mask_hold: assert property (@(posedge clk_i)
    disable iff (!nrst_i) !$past(flags[FLG_X]) |-> !flags[FLG_X])
    else $error("nmi mask went from 0 to 1");

  a_sp_xfer_plus: assert property (@(posedge clk_i)
    disable iff (!nrst_i)
    (state == ST_IDLE && req_valid_i && req_i.op == OP_SP_TO_X)
    |=> ix == 16'($past(sp) + WORD_ONE))
    else $error("sp to x not plus one");

  a_swap_both: assert property (@(posedge clk_i)
    disable iff (!nrst_i)
    (state == ST_IDLE && req_valid_i && req_i.op == OP_SWAP_D_X)
    |=> ({acc_a, acc_b} == $past(ix)) && (ix == $past({acc_a, acc_b})))
    else $error("d and x not swapped together");

  a_sign_kept: assert property (@(posedge clk_i)
    disable iff (!nrst_i)
    (state == ST_IDLE && req_valid_i && req_i.op == OP_ARITH_RIGHT &&
     req_i.opnd == OPR_ACC_A)
    |=> (acc_a[7] == $past(acc_a[7])) && (flags[FLG_C] == $past(acc_a[0])))
    else $error("arithmetic right shift lost sign or carry");

  a_push_then_dec: assert property (@(posedge clk_i)
    disable iff (!nrst_i)
    (state == ST_IDLE && req_valid_i && req_i.op == OP_PUSH_REG)
    |=> mem_o.wr && (mem_o.addr == $past(sp)) &&
        (sp == 16'($past(sp) - WORD_ONE)))
    else $error("push did not write at sp then decrement");

  a_rmw_same_addr: assert property (@(posedge clk_i)
    disable iff (!nrst_i)
    (state == ST_WAIT && (req_i.op == OP_MEM_BITS_SET ||
                          req_i.op == OP_MEM_BITS_CLEAR))
    |=> mem_o.wr && (mem_o.addr == $past(mem_o.addr)))
    else $error("bit write-back not at read address");

  a_illegal_no_access: assert property (@(posedge clk_i)
    disable iff (!nrst_i)
    (state == ST_IDLE && req_valid_i && mem_rmw && !mode_ok)
    |=> illegal_o && done_o && !mem_o.rd && !mem_o.wr)
    else $error("bad-mode bit operation touched memory");
endmodule
`default_nettype wire

// ===== hw/bsx_pkg.sv
// package for the bit, shift, stack and flags datapath
// assumes a sequencer that holds each operation on req_i until done_o
package bsx_pkg;
  // flags register bit positions
  localparam int FLG_C = 0;
  localparam int FLG_V = 1;
  localparam int FLG_Z = 2;
  localparam int FLG_N = 3;
  localparam int FLG_I = 4;
  localparam int FLG_H = 5;
  localparam int FLG_X = 6;
  localparam int FLG_S = 7;
  // reset values and constants
  localparam logic [7:0] FLAGS_RST = 8'hD0;
  localparam logic [15:0] SP_RST = 16'h00FF;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ONE = 16'h0001;

  typedef enum logic [5:0] {
    OP_NOP = 6'h00,
    OP_BIT_TEST_A = 6'h01,
    OP_BIT_TEST_B = 6'h02,
    OP_MEM_BITS_SET = 6'h03,
    OP_MEM_BITS_CLEAR = 6'h04,
    OP_BRANCH_IF_SET = 6'h05,
    OP_BRANCH_IF_CLEAR = 6'h06,
    OP_ARITH_LEFT = 6'h07,
    OP_LOGIC_LEFT = 6'h08,
    OP_ARITH_RIGHT = 6'h09,
    OP_LOGIC_RIGHT = 6'h0A,
    OP_ROTATE_LEFT = 6'h0B,
    OP_ROTATE_RIGHT = 6'h0C,
    OP_DOUBLE_LEFT = 6'h0D,
    OP_DOUBLE_LOGIC_RIGHT = 6'h0E,
    OP_SWAP_D_X = 6'h0F,
    OP_SWAP_D_Y = 6'h10,
    OP_SP_TO_X = 6'h11,
    OP_SP_TO_Y = 6'h12,
    OP_X_TO_SP = 6'h13,
    OP_Y_TO_SP = 6'h14,
    OP_ADD_B_X = 6'h15,
    OP_ADD_B_Y = 6'h16,
    OP_COMPARE_X = 6'h17,
    OP_COMPARE_Y = 6'h18,
    OP_INC_REG = 6'h19,
    OP_DEC_REG = 6'h1A,
    OP_LOAD_REG = 6'h1B,
    OP_STORE_REG = 6'h1C,
    OP_PUSH_REG = 6'h1D,
    OP_PULL_REG = 6'h1E,
    OP_CLEAR_CARRY = 6'h1F,
    OP_SET_CARRY = 6'h20,
    OP_CLEAR_INT_MASK = 6'h21,
    OP_SET_INT_MASK = 6'h22,
    OP_CLEAR_OVERFLOW = 6'h23,
    OP_SET_OVERFLOW = 6'h24,
    OP_A_TO_FLAGS = 6'h25,
    OP_FLAGS_TO_ACC_A = 6'h26
  } bsx_op_t;

  typedef enum logic [1:0] {
    OPR_ACC_A = 2'b00,
    OPR_ACC_B = 2'b01,
    OPR_MEM = 2'b10
  } bsx_opnd_t;

  typedef enum logic [1:0] {
    REG_X = 2'b00,
    REG_Y = 2'b01,
    REG_SP = 2'b10
  } bsx_reg_t;

  typedef enum logic [2:0] {
    MODE_IMM = 3'b000,
    MODE_DIR = 3'b001,
    MODE_EXT = 3'b010,
    MODE_INDX = 3'b011,
    MODE_INDY = 3'b100,
    MODE_INH = 3'b101
  } bsx_mode_t;

  // one request from the sequencer
  typedef struct packed {
    bsx_op_t op;
    bsx_opnd_t opnd;
    bsx_reg_t sel;
    bsx_mode_t mode;
    logic [15:0] addr;
    logic [7:0] mask;
    logic [15:0] word;
  } bsx_req_t;

  // one memory access toward the internal bus
  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } bsx_mem_t;
endpackage

// ===== test/bsx_mem_model.sv
// byte-wide memory standing on the datapath's internal bus
// assumes one-cycle rd/wr strobes; read byte stands while rd is high
`timescale 1ns/100ps
`default_nettype none
module bsx_mem_model (
  // clock
  input wire logic clk_i,
  // bus from the datapath
  input var bsx_pkg::bsx_mem_t mem_i,
  output logic [7:0] rdata_o
);
  import bsx_pkg::*;
  logic [7:0] mem [0:65535];
  logic [7:0] last_byte;
  logic [15:0] last_rd_addr;
  logic [15:0] last_wr_addr;
  int n_wr;
  initial begin
    last_byte = 8'h00;
    n_wr = 0;
    last_rd_addr = 16'h0000;
    last_wr_addr = 16'h0000;
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'h00;
    end
  end
  // released bus shows the inverse of the last byte read
  assign rdata_o = mem_i.rd ? mem[mem_i.addr] : ~last_byte;
  always @(posedge clk_i) begin
    if (mem_i.rd) begin
      last_byte <= mem[mem_i.addr];
      last_rd_addr <= mem_i.addr;
    end
    if (mem_i.wr) begin
      mem[mem_i.addr] <= mem_i.wdata;
      last_wr_addr <= mem_i.addr;
      n_wr <= n_wr + 1;
    end
  end
endmodule
`default_nettype wire

// ===== test/cpu_bit_shift_stack_ccr_ops_bench.sv
// self-checking bench for the bit, shift, stack and flags datapath
// assumes bsx_core and bsx_mem_model; ld loads use the immediate word, one t_compare load reads y in direct mode
`timescale 1ns/100ps
`default_nettype none
module cpu_bit_shift_stack_ccr_ops_bench;
  import bsx_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic req_valid_i = 1'b0;
  bsx_req_t req_i = '0;
  logic done_o;
  logic illegal_o;
  logic branch_taken_o;
  bsx_mem_t mem_o;
  logic [7:0] mem_rdata;
  logic [7:0] acc_a_o;
  logic [7:0] acc_b_o;
  logic [15:0] index_x_o;
  logic [15:0] index_y_o;
  logic [15:0] sp_o;
  logic [7:0] flags_o;
  logic seen_ill;
  logic seen_br;
  int n_mismatch = 0;
  int total_checks = 0;

  always #25 clk_i = ~clk_i;

  bsx_core i_dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .req_valid_i(req_valid_i),
    .req_i(req_i), .done_o(done_o), .illegal_o(illegal_o),
    .branch_taken_o(branch_taken_o), .mem_o(mem_o),
    .mem_rdata_i(mem_rdata), .acc_a_o(acc_a_o), .acc_b_o(acc_b_o),
    .index_x_o(index_x_o), .index_y_o(index_y_o), .sp_o(sp_o),
    .flags_o(flags_o)
  );
  bsx_mem_model i_mem (.clk_i(clk_i), .mem_i(mem_o), .rdata_o(mem_rdata));

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic do_op(input bsx_op_t op, input bsx_opnd_t opnd,
      input bsx_reg_t sel, input bsx_mode_t mode, input logic [15:0] addr,
      input logic [7:0] mask, input logic [15:0] word);
    int i;
    req_i = '{op, opnd, sel, mode, addr, mask, word};
    req_valid_i = 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk_i);
      #1;
      if (done_o === 1'b1) break;
    end
    if (i == 20) begin
      $display("[ERR] %0t no completion", $time);
      n_mismatch++;
      tally_and_finish();
    end
    seen_ill = illegal_o;
    seen_br = branch_taken_o;
    req_valid_i = 1'b0;
    @(posedge clk_i);
    #1;
  endtask

  task automatic op_r(input bsx_op_t op, input bsx_reg_t sel);
    do_op(op, OPR_ACC_A, sel, MODE_INH, 16'h0000, 8'h00, 16'h0000);
  endtask

  task automatic ld(input bsx_reg_t sel, input logic [15:0] v);
    do_op(OP_LOAD_REG, OPR_ACC_A, sel, MODE_IMM, 16'h0000, 8'h00, v);
  endtask

  task automatic set_ab(input logic [15:0] d);
    ld(REG_X, d);
    op_r(OP_SWAP_D_X, REG_X);
  endtask

  task automatic t_index();
    set_ab(16'hABCD);
    ld(REG_X, 16'h1234);
    op_r(OP_SWAP_D_X, REG_X);
    chk({acc_a_o, acc_b_o}, 16'h1234);
    chk(index_x_o, 16'hABCD);
    op_r(OP_SWAP_D_X, REG_X);
    chk({acc_a_o, acc_b_o, index_x_o}, 32'hABCD_1234);
    ld(REG_Y, 16'h00FF);
    op_r(OP_SWAP_D_Y, REG_Y);
    chk({acc_a_o, acc_b_o, index_y_o}, 32'h00FF_ABCD);
    op_r(OP_ADD_B_X, REG_X);
    chk(index_x_o, 16'h1333);
    op_r(OP_ADD_B_Y, REG_Y);
    chk(index_y_o, 16'hACCC);
    ld(REG_X, 16'hFFFF);
    op_r(OP_INC_REG, REG_X);
    chk(index_x_o, 16'h0000);
    op_r(OP_DEC_REG, REG_Y);
    chk(index_y_o, 16'hACCB);
  endtask

  task automatic t_stack();
    ld(REG_SP, 16'h2000);
    op_r(OP_SP_TO_X, REG_X);
    chk(index_x_o, 16'h2001);
    op_r(OP_SP_TO_Y, REG_Y);
    chk(index_y_o, 16'h2001);
    ld(REG_Y, 16'h0000);
    op_r(OP_Y_TO_SP, REG_Y);
    chk(sp_o, 16'hFFFF);
    ld(REG_X, 16'h2001);
    op_r(OP_X_TO_SP, REG_X);
    chk(sp_o, 16'h2000);
    op_r(OP_PUSH_REG, REG_X);
    chk(i_mem.last_wr_addr, 16'h2000);
    chk(i_mem.mem[16'h2000], 16'h0001);
    chk(sp_o, 16'h1FFF);
    op_r(OP_PULL_REG, REG_Y);
    chk(i_mem.last_rd_addr, 16'h2000);
    chk(sp_o, 16'h2000);
    chk(index_y_o, 16'h0001);
  endtask

  task automatic t_bits();
    int n;
    i_mem.mem[16'hFFFF] = 8'h5A;
    do_op(OP_MEM_BITS_SET, OPR_MEM, REG_X, MODE_DIR, 16'hFFFF, 8'h81, 0);
    chk(i_mem.mem[16'hFFFF], 16'h00DB);
    chk(i_mem.last_rd_addr, 16'hFFFF);
    chk(i_mem.last_wr_addr, 16'hFFFF);
    i_mem.mem[16'h0000] = 8'hA5;
    do_op(OP_MEM_BITS_CLEAR, OPR_MEM, REG_X, MODE_INDX, 0, 8'h0F, 0);
    chk(i_mem.mem[16'h0000], 16'h00A0);
    do_op(OP_BRANCH_IF_SET, OPR_MEM, REG_X, MODE_INDY, 0, 8'hA0, 0);
    chk({seen_ill, seen_br}, 2'b01);
    do_op(OP_BRANCH_IF_CLEAR, OPR_MEM, REG_X, MODE_DIR, 0, 8'h80, 0);
    chk({seen_ill, seen_br}, 2'b00);
    n = i_mem.n_wr;
    do_op(OP_MEM_BITS_SET, OPR_MEM, REG_X, MODE_EXT, 0, 8'hFF, 0);
    chk(seen_ill, 1'b1);
    do_op(OP_MEM_BITS_CLEAR, OPR_MEM, REG_X, MODE_IMM, 0, 8'hFF, 0);
    chk(seen_ill, 1'b1);
    do_op(OP_BRANCH_IF_SET, OPR_MEM, REG_X, MODE_EXT, 0, 8'h00, 0);
    chk(seen_ill, 1'b1);
    chk(i_mem.n_wr - n, 16'h0000);
    chk(i_mem.mem[16'h0000], 16'h00A0);
    set_ab(16'h0F80);
    i_mem.mem[16'h0040] = 8'hF0;
    do_op(OP_BIT_TEST_A, OPR_MEM, REG_X, MODE_DIR, 16'h0040, 0, 0);
    chk({acc_a_o, flags_o[FLG_Z]}, {8'h0F, 1'b1});
    chk(i_mem.mem[16'h0040], 16'h00F0);
    i_mem.mem[16'h8000] = 8'h80;
    do_op(OP_BIT_TEST_B, OPR_MEM, REG_X, MODE_INDY, 16'h8000, 0, 0);
    chk({acc_b_o, flags_o[FLG_N], flags_o[FLG_Z]}, 10'h202);
  endtask

  task automatic t_shift();
    bsx_op_t ops [8] = '{OP_ARITH_LEFT, OP_LOGIC_LEFT, OP_ARITH_RIGHT,
      OP_LOGIC_RIGHT, OP_ROTATE_LEFT, OP_ROTATE_RIGHT, OP_DOUBLE_LEFT,
      OP_DOUBLE_LOGIC_RIGHT};
    logic [15:0] din [8] = '{16'h8100, 16'h8100, 16'h8100, 16'h8100,
      16'h8100, 16'h8000, 16'h8001, 16'h8001};
    logic [15:0] dout [8] = '{16'h0200, 16'h0200, 16'hC000, 16'h4000,
      16'h0300, 16'hC000, 16'h0002, 16'h4000};
    logic cin [8] = '{0, 0, 0, 1, 1, 1, 0, 0};
    logic cout [8] = '{1, 1, 1, 1, 1, 0, 1, 1};
    for (int i = 0; i < 8; i++) begin
      set_ab(din[i]);
      op_r(cin[i] ? OP_SET_CARRY : OP_CLEAR_CARRY, REG_X);
      do_op(ops[i], OPR_ACC_A, REG_X, MODE_INH, 0, 0, 0);
      chk({acc_a_o, acc_b_o}, dout[i]);
      chk(flags_o[FLG_C], cout[i]);
    end
    set_ab(16'h0001);
    do_op(OP_ARITH_RIGHT, OPR_ACC_B, REG_X, MODE_INH, 0, 0, 0);
    chk({acc_b_o, flags_o[FLG_C], flags_o[FLG_Z]}, 10'h003);
    op_r(OP_SET_CARRY, REG_X);
    i_mem.mem[16'h0100] = 8'h40;
    do_op(OP_ROTATE_RIGHT, OPR_MEM, REG_X, MODE_EXT, 16'h0100, 0, 0);
    chk(i_mem.mem[16'h0100], 16'h00A0);
    chk({flags_o[FLG_N], flags_o[FLG_C]}, 2'b10);
  endtask

  task automatic t_reset();
    nrst_i = 1'b0;
    @(posedge clk_i);
    #1;
    chk(flags_o, FLAGS_RST);
    nrst_i = 1'b1;
    chk(sp_o, SP_RST);
    op_r(OP_FLAGS_TO_ACC_A, REG_X);
    chk(acc_a_o, FLAGS_RST);
  endtask

  task automatic t_flags();
    bsx_op_t ops [6] = '{OP_CLEAR_CARRY, OP_SET_CARRY, OP_CLEAR_INT_MASK,
      OP_SET_INT_MASK, OP_CLEAR_OVERFLOW, OP_SET_OVERFLOW};
    int pos [6] = '{FLG_C, FLG_C, FLG_I, FLG_I, FLG_V, FLG_V};
    for (int i = 0; i < 6; i++) begin
      op_r(ops[i], REG_X);
      chk(flags_o[pos[i]], i % 2);
    end
    set_ab(16'h0000);
    op_r(OP_A_TO_FLAGS, REG_X);
    chk(flags_o, 16'h0000);
    set_ab(16'hFF00);
    op_r(OP_A_TO_FLAGS, REG_X);
    chk(flags_o, 16'h00BF);
    set_ab(16'h0000);
    op_r(OP_FLAGS_TO_ACC_A, REG_X);
    chk(acc_a_o[FLG_S], 1'b1);
    chk(acc_a_o[FLG_X], 1'b0);
  endtask

  task automatic t_compare();
    ld(REG_X, 16'h1234);
    i_mem.mem[16'h0050] = 8'h34;
    do_op(OP_COMPARE_X, OPR_MEM, REG_X, MODE_DIR, 16'h0050, 0, 16'h1200);
    chk({index_x_o, flags_o[FLG_Z]}, {16'h1234, 1'b1});
    ld(REG_Y, 16'h1234);
    i_mem.mem[16'h0050] = 8'h35;
    do_op(OP_COMPARE_Y, OPR_MEM, REG_Y, MODE_DIR, 16'h0050, 0, 16'h1200);
    chk({index_y_o, flags_o[FLG_Z]}, {16'h1234, 1'b0});
    chk(flags_o[FLG_N], 1'b1);
    ld(REG_X, 16'hBEEF);
    do_op(OP_STORE_REG, OPR_MEM, REG_X, MODE_EXT, 16'h0300, 0, 0);
    chk({i_mem.mem[16'h0300], i_mem.mem[16'h0301]}, 16'hBEEF);
    do_op(OP_LOAD_REG, OPR_MEM, REG_Y, MODE_DIR, 16'h0301, 0, 16'hBE00);
    chk(index_y_o, 16'hBEEF);
  endtask

  initial begin
    repeat (2) @(posedge clk_i);
    #1;
    nrst_i = 1'b1;
    chk(sp_o, SP_RST);
    chk(flags_o, FLAGS_RST);
    chk({acc_a_o, acc_b_o}, 16'h0000);
    t_index();
    t_stack();
    t_bits();
    t_shift();
    t_flags();
    t_reset();
    t_compare();
    tally_and_finish();
  end
endmodule
`default_nettype wire
